// ---- hw/sfd_pkg.sv ----
// Package: constants for the single-phase fan drive control block
package sfd_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  // Lock retry timing, in milliseconds as specified
  localparam int unsigned LOCK_ON_MS = 400;
  localparam int unsigned LOCK_OFF_MS = 4000;
  // Time without a Hall edge that counts as a locked rotor
  localparam int unsigned LOCK_DETECT_MS = 400;
  localparam int unsigned LOCK_ON_CYC = LOCK_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned LOCK_OFF_CYC = LOCK_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned LOCK_DETECT_CYC = LOCK_DETECT_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W = 32;
  // Reset values of the outputs
  localparam logic DRV_RST = 1'b0;
  localparam logic SIG_RST = 1'b0;
  // Alarm output levels
  localparam logic ALARM_OK = 1'b0;
  localparam logic ALARM_LOCKED = 1'b1;
  typedef enum logic [1:0] {SFD_RUN, SFD_LOCK_OFF, SFD_LOCK_ON} sfd_state_e;
endpackage : sfd_pkg

// ---- hw/sfd_hall_if.sv ----
// Interface: Hall edge event and lock status between core and signal generator
`timescale 1ns/1ps
interface sfd_hall_if;
  logic hall_edge;
  logic locked;
  modport core (output hall_edge, output locked);
  modport sig (input hall_edge, input locked);
endinterface : sfd_hall_if

// ---- hw/sfd_signal_gen.sv ----
// Signal generator: tachometer or lock alarm output
`timescale 1ns/1ps
module sfd_signal_gen
  import sfd_pkg::*;
#(
  parameter bit ALARM_VARIANT = 1'b0
) (
  input wire logic clock,
  input wire logic sys_rst,
  sfd_hall_if.sig ev,
  output logic sig_q
);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sig_q <= ALARM_VARIANT ? ALARM_OK : SIG_RST;
    end else if (ALARM_VARIANT) begin
      sig_q <= ev.locked ? ALARM_LOCKED : ALARM_OK;
    end else if (ev.hall_edge) begin
      sig_q <= ~sig_q;
    end
  end

  tach_toggle_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!ALARM_VARIANT && ev.hall_edge) |=> (sig_q != $past(sig_q)))
    else $error("tach did not toggle on Hall edge");
  alarm_level_a: assert property (@(posedge clock) disable iff (sys_rst)
    ALARM_VARIANT |=> (sig_q == $past(ev.locked)))
    else $error("alarm level does not follow lock state");
endmodule : sfd_signal_gen

// ---- hw/sfd_fan_ctrl.sv ----
// Top: single-phase fan drive control with lock retry and tach/alarm output
`timescale 1ns/1ps
module sfd_fan_ctrl
  import sfd_pkg::*;
#(
  parameter bit ALARM_VARIANT = 1'b0,
  parameter int unsigned ON_CYC = LOCK_ON_CYC,
  parameter int unsigned OFF_CYC = LOCK_OFF_CYC,
  parameter int unsigned DETECT_CYC = LOCK_DETECT_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hall_north,
  input wire logic pwm_in,
  input wire logic thermal_trip,
  output logic drive1_q,
  output logic drive2_q,
  output logic tach_out
);
  // Elaboration checks: a single-cycle interval leaves no room for the restart compare
  if (ON_CYC < 2) begin : g_on_chk
    $error("ON_CYC must be at least 2");
  end
  if (OFF_CYC < 2) begin : g_off_chk
    $error("OFF_CYC must be at least 2");
  end
  if (DETECT_CYC < 2) begin : g_det_chk
    $error("DETECT_CYC must be at least 2");
  end

  sfd_hall_if hif ();

  logic hall_q;
  logic lock_q;
  sfd_state_e state_q;
  logic [TMR_W-1:0] tmr_q;
  logic edge_seen;
  logic drive_en;
  logic tmr_detect_end;
  logic tmr_off_end;
  logic tmr_on_end;
  logic tmr_restart;
  logic lock_event;
  logic spin_back;

  // Previous Hall level; a difference from the pin is one polarity transition
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hall_q <= 1'b0;
    end else begin
      hall_q <= hall_north;
    end
  end
  assign edge_seen = hall_q != hall_north;
  assign hif.hall_edge = edge_seen;
  assign hif.locked = lock_q;

  // Interval ends; compares use count minus one because the timer starts at zero
  assign tmr_detect_end = tmr_q >= TMR_W'(DETECT_CYC - 1);
  assign tmr_off_end = tmr_q >= TMR_W'(OFF_CYC - 1);
  assign tmr_on_end = tmr_q >= TMR_W'(ON_CYC - 1);
  // No Hall transition for a whole detect interval counts as a locked rotor
  assign lock_event = (state_q == SFD_RUN) && !edge_seen && tmr_detect_end;
  // A transition in a retry on phase means the rotor turns again
  assign spin_back = (state_q == SFD_LOCK_ON) && edge_seen;

  // Phase of the lock shutdown and retry schedule
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= SFD_RUN;
    end else begin
      case (state_q)
        SFD_RUN: begin
          if (lock_event) begin
            state_q <= SFD_LOCK_OFF;
          end
        end
        SFD_LOCK_OFF: begin
          if (tmr_off_end) begin
            state_q <= SFD_LOCK_ON;
          end
        end
        SFD_LOCK_ON: begin
          if (edge_seen) begin
            state_q <= SFD_RUN;
          end else if (tmr_on_end) begin
            state_q <= SFD_LOCK_OFF;
          end
        end
        default: begin
          state_q <= SFD_RUN;
        end
      endcase
    end
  end

  // One timer serves detection and both retry phases; it restarts on each phase change
  always_comb begin
    tmr_restart = 1'b1;
    case (state_q)
      SFD_RUN: begin
        tmr_restart = edge_seen || tmr_detect_end;
      end
      SFD_LOCK_OFF: begin
        tmr_restart = tmr_off_end;
      end
      SFD_LOCK_ON: begin
        tmr_restart = edge_seen || tmr_on_end;
      end
      default: begin
        tmr_restart = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tmr_q <= '0;
    end else if (tmr_restart) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  // Lock flag: set on detection and held through every retry until the rotor turns
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lock_q <= 1'b0;
    end else if (lock_event) begin
      lock_q <= 1'b1;
    end else if (spin_back) begin
      lock_q <= 1'b0;
    end
  end

  // Pull-up on the pad means an open pin already arrives as 1 here
  // Low duty still drives in every high phase outside lock off and thermal trip; of PWM inputs only a constant low stops torque
  assign drive_en = pwm_in && !thermal_trip && (state_q != SFD_LOCK_OFF);

  // Registered so each pin comes from a flop; costs one cycle of latency

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      drive1_q <= DRV_RST;
      drive2_q <= DRV_RST;
    end else begin
      drive1_q <= drive_en && !hall_north;
      drive2_q <= drive_en && hall_north;
    end
  end

  sfd_signal_gen #(.ALARM_VARIANT(ALARM_VARIANT)) u_sig (
    .clock(clock),
    .sys_rst(sys_rst),
    .ev(hif.sig),
    .sig_q(tach_out)
  );

  lock_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == SFD_LOCK_OFF) |=> (!drive1_q && !drive2_q))
    else $error("drive active during lock off");
  thermal_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    thermal_trip |=> (!drive1_q && !drive2_q))
    else $error("drive active during thermal trip");
  pwm_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
    (drive1_q || drive2_q) |-> $past(pwm_in))
    else $error("drive without PWM high");
  pwm_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
    (pwm_in && !thermal_trip && state_q == SFD_RUN) |=> (drive1_q || drive2_q))
    else $error("no drive with PWM high in run");
  pole_map_a: assert property (@(posedge clock) disable iff (sys_rst)
    (drive1_q || drive2_q) |-> (drive2_q == $past(hall_north)) && (drive1_q != drive2_q))
    else $error("drive outputs do not match Hall pole");
  retry_on_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == SFD_LOCK_OFF && tmr_q == TMR_W'(OFF_CYC - 1)) |=> (state_q == SFD_LOCK_ON))
    else $error("retry did not start after off interval");
  retry_end_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == SFD_LOCK_ON && tmr_q == TMR_W'(ON_CYC - 1) && !edge_seen) |=> (state_q == SFD_LOCK_OFF))
    else $error("retry on phase did not end");
  lock_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(lock_q) |-> (state_q == SFD_LOCK_OFF) && (tmr_q == '0))
    else $error("lock flag without lock off start");

  // Lock schedule and bridge checks
  lock_entry_a: assert property (@(posedge clock) disable iff (sys_rst)
    lock_event |=> (state_q == SFD_LOCK_OFF) && lock_q)
    else $error("locked rotor did not start shutdown");

  lock_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    spin_back |=> (!lock_q && state_q == SFD_RUN))
    else $error("lock not cleared after rotor restart");

  detect_bound_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == SFD_RUN) |-> (tmr_q < TMR_W'(DETECT_CYC)))
    else $error("detect timer ran past its interval");

  off_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == SFD_LOCK_OFF && !tmr_off_end) |=> (state_q == SFD_LOCK_OFF))
    else $error("off phase cut short");

  on_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == SFD_LOCK_ON && !tmr_on_end && !edge_seen) |=> (state_q == SFD_LOCK_ON))
    else $error("retry on phase cut short");

  retry_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == SFD_LOCK_ON && pwm_in && !thermal_trip) |=> (drive1_q || drive2_q))
    else $error("no drive during retry on phase");

  drive_excl_a: assert property (@(posedge clock) disable iff (sys_rst)
    !(drive1_q && drive2_q))
    else $error("both drive outputs high");
endmodule : sfd_fan_ctrl

// ---- verif/sfd_host_model.sv ----
// Host model: speed PWM source for the fan drive
`timescale 1ns/1ps
module sfd_host_model (
  input wire logic clock,
  input wire logic float_en,
  input wire logic [7:0] period,
  input wire logic [7:0] high_cyc,
  output logic pwm_in
);
  logic [7:0] cnt_q = 8'h00;
  // Short period keeps the rate far above the 2 kHz floor
  always_ff @(negedge clock) begin
    cnt_q <= (cnt_q + 8'h01 >= period) ? 8'h00 : cnt_q + 8'h01;
  end
  // A released pin is pulled high by the pad
  assign pwm_in = float_en ? 1'b1 : (cnt_q < high_cyc);
endmodule : sfd_host_model

// ---- verif/sfd_fan_ctrl_tb.sv ----
// Testbench: fan drive control against a PWM host model
`timescale 1ns/1ps
module sfd_fan_ctrl_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic hall_north = 1'b0;
  logic thermal_trip = 1'b0;
  logic spin = 1'b0;
  logic float_en = 1'b0;
  logic [7:0] high_cyc = 8'h01;
  logic pwm_in, drive1_q, drive2_q, tach_out, hall_p, tach_exp, alarm_out;
  logic [2:0] hcnt = 3'h0;
  int errors = 0;
  int total_checks = 0;
  int n;
  always #10 clock = ~clock;
  sfd_host_model sfd_host_model_inst (.clock(clock), .float_en(float_en), .period(8'h0a), .high_cyc(high_cyc),
    .pwm_in(pwm_in));
  sfd_fan_ctrl #(.ALARM_VARIANT(1'b0), .ON_CYC(10), .OFF_CYC(100), .DETECT_CYC(20)) sfd_fan_ctrl_inst (
    .clock(clock), .sys_rst(sys_rst), .hall_north(hall_north), .pwm_in(pwm_in), .thermal_trip(thermal_trip),
    .drive1_q(drive1_q), .drive2_q(drive2_q), .tach_out(tach_out));
  // Alarm build on the same inputs; its drive pins duplicate the tach build
  sfd_fan_ctrl #(.ALARM_VARIANT(1'b1), .ON_CYC(10), .OFF_CYC(100), .DETECT_CYC(20)) sfd_fan_ctrl_alm_inst (
    .clock(clock), .sys_rst(sys_rst), .hall_north(hall_north), .pwm_in(pwm_in), .thermal_trip(thermal_trip),
    .drive1_q(), .drive2_q(), .tach_out(alarm_out));
  // Hall flips every 8 cycles, well inside the lock detect time
  always @(negedge clock) begin
    hcnt <= hcnt + 3'h1;
    if (spin && hcnt == 3'h6) hall_north <= ~hall_north;
  end
  always @(posedge clock) begin
    hall_p <= hall_north;
    tach_exp <= sys_rst ? 1'b0 : tach_exp ^ (hall_north !== hall_p);
  end
  task check(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : check
  task test_done;
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // Outputs after each edge follow the inputs taken at that edge
  task automatic run_chk(input int cnt);
    logic p, h, t;
    repeat (cnt) begin
      @(posedge clock);
      p = pwm_in;
      h = hall_north;
      t = thermal_trip;
      #1;
      check("drive1_q", p & ~h & ~t, drive1_q);
      check("drive2_q", p & h & ~t, drive2_q);
      check("tach_out", tach_exp, tach_out);
      check("alarm_out", sfd_pkg::ALARM_OK, alarm_out);
    end
  endtask : run_chk
  task automatic wait_lvl(input logic v, input int lim);
    n = 0;
    while (drive2_q !== v) begin
      @(posedge clock);
      #1;
      n++;
      if (n > lim) begin
        errors++;
        test_done();
      end
    end
  endtask : wait_lvl
  task automatic lock_chk;
    @(negedge clock);
    spin = 1'b0;
    @(negedge clock);
    hall_north = 1'b1;
    float_en = 1'b1;
    // Start from a driving coil so the next falling level is the lock shutdown
    wait_lvl(1'b1, 4);
    wait_lvl(1'b0, 40);
    check("alarm_out", sfd_pkg::ALARM_LOCKED, alarm_out);
    wait_lvl(1'b1, 200);
    check("off_len", 1'b1, n == 100);
    check("alarm_out", sfd_pkg::ALARM_LOCKED, alarm_out);
    wait_lvl(1'b0, 50);
    check("on_len", 1'b1, n == 10);
    check("drive1_q", 1'b0, drive1_q);
    wait_lvl(1'b1, 200);
    check("retry_len", 1'b1, n == 100);
    // A Hall transition inside the retry on phase ends the lock
    @(negedge clock);
    hall_north = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check("alarm_out", sfd_pkg::ALARM_OK, alarm_out);
    check("drive1_q", 1'b1, drive1_q);
  endtask : lock_chk
  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    spin = 1'b1;
    run_chk(60);
    @(negedge clock);
    high_cyc = 8'h00;
    run_chk(30);
    @(negedge clock);
    float_en = 1'b1;
    run_chk(30);
    @(negedge clock);
    thermal_trip = 1'b1;
    run_chk(30);
    @(negedge clock);
    thermal_trip = 1'b0;
    lock_chk();
    test_done();
  end
endmodule : sfd_fan_ctrl_tb
